//--- verilog/pwrseq_pkg.sv
// constants for the power sequence timing slice
package pwrseq_pkg;
  // clock and time base
  localparam int unsigned CLK_MHZ          = 125;
  localparam int unsigned MS_US            = 1000;
  localparam int unsigned MS_CYCLES        = CLK_MHZ * MS_US;
  localparam int unsigned HALF_MS_CYCLES   = MS_CYCLES / 2;
  // supervision timeout codes
  localparam logic [1:0]  TMO_INDEF        = 2'h0;
  localparam logic [1:0]  TMO_HALF_MS      = 2'h1;
  localparam logic [1:0]  TMO_1MS          = 2'h2;
  localparam logic [1:0]  TMO_2MS          = 2'h3;
  // cold reset delays in ms
  localparam logic [7:0]  CRD_MS_1         = 8'h0f;
  localparam logic [7:0]  CRD_MS_2         = 8'h1f;
  localparam logic [7:0]  CRD_MS_3         = 8'h3f;
  localparam logic [7:0]  CRD_MS_4         = 8'h5f;
  localparam logic [7:0]  CRD_MS_5         = 8'h7f;
  // register byte addresses
  localparam logic [7:0]  ADDR_CONFIG      = 8'h00;
  localparam logic [7:0]  ADDR_PIN0_DELAY  = 8'h04;
  localparam logic [7:0]  ADDR_CONTROL     = 8'h08;
  localparam logic [7:0]  ADDR_STATUS      = 8'h0c;
  localparam logic [7:0]  ADDR_IRQ_STATUS  = 8'h10;
  localparam logic [7:0]  ADDR_IRQ_ENABLE  = 8'h14;
  localparam logic [7:0]  ADDR_IRQ_CLEAR   = 8'h18;
  // config fields
  localparam int unsigned CFG_TMO_LSB      = 3;
  localparam int unsigned CFG_CRD_LSB      = 0;
  localparam logic [4:0]  CONFIG_RESET     = 5'h17;
  localparam logic [7:0]  PIN0_RESET       = 8'h00;
  // control bits
  localparam int unsigned CTL_START        = 0;
  localparam int unsigned CTL_PWROFF       = 1;
  localparam int unsigned CTL_PGOOD_MODE   = 2;
  // irq bits
  localparam int unsigned IRQ_STANDBY      = 0;
  localparam int unsigned IRQ_FAULT        = 1;
  localparam int unsigned IRQ_PIN0         = 2;
  localparam int unsigned IRQ_WIDTH        = 3;

  typedef enum logic [2:0] {
    ST_OFF       = 3'h0,
    ST_SUPERVISE = 3'h1,
    ST_STANDBY   = 3'h2,
    ST_FAULT_OUT = 3'h3,
    ST_COLD_WAIT = 3'h4,
    ST_POWER_ON  = 3'h5
  } seq_state_t;
endpackage : pwrseq_pkg

//--- verilog/power_sequence_timing_config.sv
// power sequence supervision, cold reset delay and pin zero power-on delay
//
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/1ps
module power_sequence_timing_config
  import pwrseq_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        io_supply_good_flag,
  input  wire logic [9:0]  regulator_good,
  output logic             multipurpose_pin_zero,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////
  logic        good_s1_r, good_s2_r;
  logic [9:0]  reg_s1_r, reg_s2_r;
  logic [4:0]  config_r;
  logic [7:0]  pin0_delay_r;
  logic        pgood_mode_r, pin0_done_r;
  logic [IRQ_WIDTH-1:0] irq_stat_r, irq_en_r, irq_set;
  seq_state_t  state_r, state_nxt;
  logic [16:0] tick_cnt_r;
  logic [7:0]  ms_cnt_r;
  logic        half_cnt_done, tmo_expired;
  logic        ms_tick, phase_start;
  logic        wr_en, rd_en, start_req, off_req;
  logic [1:0]  tmo_code;
  logic [2:0]  crd_code;
  logic [7:0]  crd_ms;

  assign tmo_code = config_r[CFG_TMO_LSB +: 2];
  assign crd_code = config_r[CFG_CRD_LSB +: 3];

  // pins cross into pclk through two flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      good_s1_r <= 1'b0;
      good_s2_r <= 1'b0;
      reg_s1_r  <= 10'h000;
      reg_s2_r  <= 10'h000;
    end
    else
    begin
      good_s1_r <= io_supply_good_flag;
      good_s2_r <= good_s1_r;
      reg_s1_r  <= regulator_good;
      reg_s2_r  <= reg_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // apb slave, zero wait states
  assign pready    = 1'b1;
  assign pslverr   = 1'b0;
  assign wr_en     = psel & penable & pwrite;
  assign rd_en     = psel & ~penable & ~pwrite;  // read data is loaded in the setup cycle
  assign start_req = wr_en && paddr == ADDR_CONTROL && pwdata[CTL_START];
  assign off_req   = wr_en && paddr == ADDR_CONTROL && pwdata[CTL_PWROFF];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      config_r     <= CONFIG_RESET;
      pin0_delay_r <= PIN0_RESET;
      pgood_mode_r <= 1'b0;
      irq_en_r     <= '0;
    end
    else if (wr_en)
    begin
      if (paddr == ADDR_CONFIG)
        config_r <= pwdata[4:0];
      if (paddr == ADDR_PIN0_DELAY)
        pin0_delay_r <= {1'b0, pwdata[6:0]};
      if (paddr == ADDR_CONTROL)
        pgood_mode_r <= pwdata[CTL_PGOOD_MODE];
      if (paddr == ADDR_IRQ_ENABLE)
        irq_en_r <= pwdata[IRQ_WIDTH-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (rd_en)
    begin
      unique case (paddr)
        ADDR_CONFIG:     prdata <= {27'h0, config_r};
        ADDR_PIN0_DELAY: prdata <= {24'h0, pin0_delay_r};
        ADDR_CONTROL:    prdata <= {29'h0, pgood_mode_r, 2'h0};
        ADDR_STATUS:     prdata <= {27'h0, pin0_done_r, good_s2_r, state_r};
        ADDR_IRQ_STATUS: prdata <= {29'h0, irq_stat_r};
        ADDR_IRQ_ENABLE: prdata <= {29'h0, irq_en_r};
        default:         prdata <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // millisecond time base, restarted with each phase so delays are exact
  assign phase_start   = state_nxt != state_r;
  assign ms_tick       = tick_cnt_r == 17'(MS_CYCLES - 1);
  assign half_cnt_done = tick_cnt_r == 17'(HALF_MS_CYCLES - 1);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tick_cnt_r <= 17'h0;
      ms_cnt_r   <= 8'h00;
    end
    else if (phase_start)
    begin
      tick_cnt_r <= 17'h0;
      ms_cnt_r   <= 8'h00;
    end
    else if (ms_tick)
    begin
      tick_cnt_r <= 17'h0;
      if (ms_cnt_r != 8'hff)
        ms_cnt_r <= ms_cnt_r + 8'h01;
    end
    else
      tick_cnt_r <= tick_cnt_r + 17'h1;
  end

  always_comb
  begin
    unique case (crd_code)
      3'h1:    crd_ms = CRD_MS_1;
      3'h2:    crd_ms = CRD_MS_2;
      3'h3:    crd_ms = CRD_MS_3;
      3'h4:    crd_ms = CRD_MS_4;
      3'h5:    crd_ms = CRD_MS_5;
      default: crd_ms = 8'h00;  // codes 6/7 undefined: treated as no delay
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  always_comb
  begin
    unique case (tmo_code)
      TMO_INDEF:   tmo_expired = 1'b0;
      TMO_HALF_MS: tmo_expired = half_cnt_done;
      TMO_1MS:     tmo_expired = ms_tick;
      TMO_2MS:     tmo_expired = ms_tick && ms_cnt_r == 8'h01;
    endcase
  end

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      ST_OFF:
        if (start_req)
          state_nxt = ST_SUPERVISE;
      ST_SUPERVISE:
        if (good_s2_r)
          state_nxt = ST_STANDBY;
        else if (tmo_expired)
          state_nxt = ST_FAULT_OUT;
      ST_STANDBY:
        if (start_req)
          state_nxt = ST_POWER_ON;
      ST_POWER_ON:
        if (off_req)
          state_nxt = ST_COLD_WAIT;
      ST_COLD_WAIT:
        if (crd_ms == 8'h00 || (ms_tick && ms_cnt_r == crd_ms - 8'h01))
          state_nxt = ST_POWER_ON;
      ST_FAULT_OUT:
        if (off_req)
          state_nxt = ST_OFF;
      default:
        state_nxt = ST_OFF;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_r <= ST_OFF;
    else
      state_r <= state_nxt;
  end

  // pin zero: delayed power-on marker or selected regulator good
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pin0_done_r <= 1'b0;
    else if (state_r != ST_POWER_ON || phase_start)
      pin0_done_r <= 1'b0;
    else if (pin0_delay_r[6:0] == 7'h00 || ms_cnt_r >= {1'b0, pin0_delay_r[6:0]})
      pin0_done_r <= 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      multipurpose_pin_zero <= 1'b0;
    else if (pgood_mode_r)
      multipurpose_pin_zero <= pin0_delay_r[3:0] <= 4'h9 ? reg_s2_r[pin0_delay_r[3:0]] : 1'b0;
    else
      multipurpose_pin_zero <= pin0_done_r;
  end

  ////////////////////////////////////////////////////////////////////
  always_comb
  begin
    irq_set              = '0;
    irq_set[IRQ_STANDBY] = phase_start && state_nxt == ST_STANDBY;
    irq_set[IRQ_FAULT]   = phase_start && state_nxt == ST_FAULT_OUT;
    irq_set[IRQ_PIN0]    = state_r == ST_POWER_ON && !phase_start && !pin0_done_r
                           && (pin0_delay_r[6:0] == 7'h00 || ms_cnt_r >= {1'b0, pin0_delay_r[6:0]});
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_stat_r <= '0;
    else if (wr_en && paddr == ADDR_IRQ_CLEAR)
      irq_stat_r <= (irq_stat_r & ~pwdata[IRQ_WIDTH-1:0]) | irq_set;
    else
      irq_stat_r <= irq_stat_r | irq_set;
  end

  assign irq = |(irq_stat_r & irq_en_r);

  ////////////////////////////////////////////////////////////////////
  logic [23:0] phase_cyc_r;  // cycles since the last state change, apart from the time base it checks
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      phase_cyc_r <= 24'h00_0000;
    else
      phase_cyc_r <= phase_start ? 24'h00_0000 : phase_cyc_r + {23'h00_0000, ~&phase_cyc_r};

  a_good_to_standby: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == ST_SUPERVISE && good_s2_r |=> state_r == ST_STANDBY)
    else $error("good flag did not lead to standby");

  a_expiry_to_fault: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == ST_SUPERVISE && !good_s2_r && tmo_expired |=> state_r == ST_FAULT_OUT)
    else $error("timeout did not lead to fault");

  a_fault_window: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == ST_SUPERVISE && state_nxt == ST_FAULT_OUT
    |-> phase_cyc_r == 24'(tmo_code == TMO_2MS ? 2 * MS_CYCLES - 1 :
                           tmo_code == TMO_1MS ? MS_CYCLES - 1 : HALF_MS_CYCLES - 1))
    else $error("supervision timeout fired at the wrong time");

  a_indef_no_fault: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == ST_SUPERVISE && tmo_code == TMO_INDEF |=> state_r != ST_FAULT_OUT)
    else $error("indefinite timeout faulted");

  a_cold_wait_len: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == ST_COLD_WAIT && state_nxt == ST_POWER_ON && crd_ms != 8'h00
    |-> phase_cyc_r == 24'(crd_ms * MS_CYCLES - 1))
    else $error("cold reset delay has the wrong length");

  a_cold_zero_skip: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == ST_COLD_WAIT && crd_code == 3'h0 |=> state_r == ST_POWER_ON)
    else $error("zero cold delay did not skip");

  a_pin_delay_hold: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(pin0_done_r) |-> $past(ms_cnt_r) >= {1'b0, pin0_delay_r[6:0]} && state_r == ST_POWER_ON)
    else $error("pin zero delay released early");

  a_pin_off_clear: assert property (@(posedge pclk) disable iff (!presetn)
    state_r != ST_POWER_ON |=> !pin0_done_r)
    else $error("pin zero marker outside power-on");

  a_tick_restart: assert property (@(posedge pclk) disable iff (!presetn)
    phase_start |=> tick_cnt_r == 17'h0 && ms_cnt_r == 8'h00)
    else $error("time base not restarted at phase start");

endmodule : power_sequence_timing_config

//--- verif/power_sequence_timing_config_bench.sv
// self-checking bench for the power sequence timing slice
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin fails++; \
  $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module power_sequence_timing_config_bench;
  import pwrseq_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        io_supply_good_flag = 1'b0;
  logic [9:0]  regulator_good = 10'h000;
  logic        multipurpose_pin_zero;
  logic        irq;
  logic [31:0] q;
  int          fails = 0;
  int          tests_run = 0;
  int          cyc = 0;

  power_sequence_timing_config DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .io_supply_good_flag(io_supply_good_flag), .regulator_good(regulator_good),
    .multipurpose_pin_zero(multipurpose_pin_zero), .irq(irq));

  always #4 pclk = ~pclk;

  //////////////////////////////////////////////////////////////////////////////
  task give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict

  // the longest scenario is the half-millisecond supervision window
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 90000)
    begin
      fails++;
      give_verdict;
    end
  end

  task tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick

  // one apb transfer; waits on pready rather than assuming a latency
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    q = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task do_reset(input int n);
    @(posedge pclk);
    presetn <= 1'b0;
    tick(n);
    presetn <= 1'b1;
  endtask : do_reset

  //////////////////////////////////////////////////////////////////////////////
  task t_regs;
    apb(1'b0, ADDR_CONFIG, 32'h0);
    `CHK("config reset", {27'h0, CONFIG_RESET}, q)
    apb(1'b1, ADDR_PIN0_DELAY, 32'h0000_00ff);
    apb(1'b0, ADDR_PIN0_DELAY, 32'h0);
    `CHK("pin0 delay bit7", 32'h0000_007f, q)
    apb(1'b0, 8'h1c, 32'h0);
    `CHK("unmapped read", 32'h0, q)
    `CHK("no slave error", 1'b0, pslverr)
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK("state after reset", ST_OFF, q[2:0])
    $display("t_regs done");
  endtask : t_regs

  task t_standby;
    apb(1'b1, ADDR_CONFIG, 32'h0);
    apb(1'b1, ADDR_IRQ_ENABLE, 32'h7);
    apb(1'b1, ADDR_CONTROL, 32'h1);
    tick(300);
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK("indefinite wait", ST_SUPERVISE, q[2:0])
    io_supply_good_flag <= 1'b1;
    tick(6);
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK("standby on good", ST_STANDBY, q[2:0])
    `CHK("irq standby", 1'b1, irq)
    apb(1'b0, ADDR_IRQ_STATUS, 32'h0);
    `CHK("irq status standby", 1'b1, q[IRQ_STANDBY])
    apb(1'b1, ADDR_IRQ_CLEAR, 32'h7);
    tick(1);
    `CHK("irq cleared", 1'b0, irq)
    $display("t_standby done");
  endtask : t_standby

  task t_pin_cold;
    apb(1'b1, ADDR_PIN0_DELAY, 32'h0);
    apb(1'b1, ADDR_CONTROL, 32'h1);
    tick(4);
    `CHK("pin at delay 0", 1'b1, multipurpose_pin_zero)
    apb(1'b1, ADDR_CONTROL, 32'h2);
    tick(4);
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK("cold code 0", ST_POWER_ON, q[2:0])
    `CHK("status good flag", 1'b1, q[3])
    `CHK("status pin done", 1'b1, q[4])
    apb(1'b0, ADDR_IRQ_STATUS, 32'h0);
    `CHK("irq status pin", 1'b1, q[IRQ_PIN0])
    $display("t_pin_cold done");
  endtask : t_pin_cold

  task t_pgood;
    int s;
    apb(1'b1, ADDR_CONTROL, 32'h4);
    for (s = 0; s < 10; s++)
    begin
      apb(1'b1, ADDR_PIN0_DELAY, s);
      regulator_good <= 10'h001 << s;
      tick(6);
      `CHK("pgood follows", 1'b1, multipurpose_pin_zero)
      regulator_good <= ~(10'h001 << s);
      tick(6);
      `CHK("pgood drops", 1'b0, multipurpose_pin_zero)
    end
    regulator_good <= 10'h3ff;
    apb(1'b1, ADDR_PIN0_DELAY, 32'h0000_000a);
    tick(6);
    `CHK("pgood code 10", 1'b0, multipurpose_pin_zero)
    $display("t_pgood done");
  endtask : t_pgood

  task t_fault;
    do_reset(2);
    io_supply_good_flag <= 1'b0;
    apb(1'b1, ADDR_CONFIG, {27'h0, TMO_HALF_MS, 3'h0});
    apb(1'b1, ADDR_IRQ_ENABLE, 32'h2);
    apb(1'b1, ADDR_CONTROL, 32'h1);
    tick(HALF_MS_CYCLES - 600);
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK("no fault early", ST_SUPERVISE, q[2:0])
    tick(600);
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK("fault at expiry", ST_FAULT_OUT, q[2:0])
    `CHK("irq fault", 1'b1, irq)
    apb(1'b1, ADDR_CONTROL, 32'h2);
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK("fault to off", ST_OFF, q[2:0])
    $display("t_fault done");
  endtask : t_fault

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    tick(16);
    presetn <= 1'b1;
    t_regs;
    t_standby;
    t_pin_cold;
    t_pgood;
    t_fault;
    give_verdict;
  end
endmodule : power_sequence_timing_config_bench
